// ==== verilog/hst_params.svh ====
/*
 * Offsets, reset values and timing counts of the hot-swap sequence timers.
 * Assumes a 50 MHz core clock and a byte-wide register port from the serial slave.
 */
`ifndef HST_PARAMS_SVH
`define HST_PARAMS_SVH

`define HST_CLK_NS          20
`define HST_TICK_NS         250000
`define HST_TICK_CYCLES     ((`HST_TICK_NS + `HST_CLK_NS - 1) / `HST_CLK_NS)
`define HST_DUTY_SCALE      28

`define HST_REG_COUNT       5
`define HST_OFS_INIT_DETECT 3'h0
`define HST_OFS_SLOTS_01    3'h1
`define HST_OFS_SLOTS_23    3'h2
`define HST_OFS_RETRY_TERM  3'h3
`define HST_OFS_REG_FILTER  3'h4

`define HST_RST_INIT_DETECT 8'h88
`define HST_RST_SLOTS_01    8'h88
`define HST_RST_SLOTS_23    8'h88
`define HST_RST_RETRY_TERM  8'hb8
`define HST_RST_REG_FILTER  8'h88

`endif

// ==== verilog/hst_pkg.sv ====
/*
 * Types of the hot-swap sequence timers.
 * Assumes hst_params.svh is included by the design file that uses them.
 */
package hst_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DETECT,
      ST_RAMP,
      ST_SLOT,
      ST_TERM,
      ST_RUN,
      ST_FAULT
   } hst_state_t;

   // Laid out as {byte 4, byte 3, byte 2, byte 1, byte 0}, high nibble first.
   typedef struct packed {
      logic [3:0] reg_sub;
      logic [3:0] filt;
      logic [3:0] duty;
      logic [3:0] term;
      logic [3:0] slot3;
      logic [3:0] slot2;
      logic [3:0] slot1;
      logic [3:0] slot0;
      logic [3:0] reg_init;
      logic [3:0] detect;
   } hst_cfg_t;

   typedef struct packed {
      logic       pin_detect;
      logic       under_v;
      logic       over_v;
      logic [3:0] good;
      logic       regulating;
      logic       fet_on;
   } hst_pins_t;

endpackage

// ==== verilog/hst_timers.sv ====
/*
 * Hot-swap sequence timers: five timer registers, a 0.25 ms time base, the
 * pin-detect delay, the four-slot converter cascade, regulation limits,
 * the voltage filter and the fault retry delay.
 * Assumes the serial slave drives the register port on this clock, and that
 * analog comparator levels arrive asynchronously on the pin inputs.
 */
`include "hst_params.svh"

module hst_timers #(
   parameter int TICK_CYCLES = `HST_TICK_CYCLES
) (
   input  wire logic               clock,
   input  wire logic               arst_n,
   input  wire logic               cfg_wr,
   input  wire logic [2:0]         cfg_addr,
   input  wire logic [7:0]         cfg_wdata,
   output logic      [7:0]         cfg_rdata,
   input  wire logic               config_lock,
   input  wire logic               auto_fault_clear,
   input  wire logic               voltage_filter_en,
   input  wire logic               fault_clear,
   input  wire logic               pin_detect_in,
   input  wire logic               under_voltage,
   input  wire logic               over_voltage,
   input  wire logic [3:0]         converter_good_in,
   input  wire logic               regulating_in,
   input  wire logic               fet_on_in,
   output logic                    high_side_gate,
   output logic      [3:0]         converter_enable_out,
   output logic                    fault_out,
   output hst_pkg::hst_state_t     seq_state
);
   import hst_pkg::*;

   // The time base counter is sixteen bits wide and needs at least two clocks per tick.
   if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
   begin
      $error("TICK_CYCLES must lie between 2 and 65535.");
   end

   function automatic logic [11:0] ticks_of(input logic [3:0] code);
      case (code)
         4'h0: ticks_of = 12'h001;
         4'h1: ticks_of = 12'h008;
         4'h2: ticks_of = 12'h020;
         4'h3: ticks_of = 12'h030;
         4'h4: ticks_of = 12'h040;
         4'h5: ticks_of = 12'h060;
         4'h6: ticks_of = 12'h080;
         4'h7: ticks_of = 12'h0c0;
         4'h8: ticks_of = 12'h100;
         4'h9: ticks_of = 12'h180;
         4'ha: ticks_of = 12'h200;
         4'hb: ticks_of = 12'h300;
         4'hc: ticks_of = 12'h400;
         4'hd: ticks_of = 12'h600;
         4'he: ticks_of = 12'h800;
         default: ticks_of = 12'hc00;
      endcase
   endfunction

   logic [39:0] cfg_bytes_reg;
   hst_cfg_t    cfg;
   hst_pins_t   meta_reg;
   hst_pins_t   pins;
   logic [15:0] tick_cnt_reg;
   logic        tick_reg;
   hst_state_t  state_reg;
   hst_state_t  state_next;
   logic [1:0]  slot_reg;
   logic [16:0] seq_cnt_reg;
   logic [11:0] reg_cnt_reg;
   logic [11:0] filt_cnt_reg;
   logic        volt_fault_reg;
   logic        first_pwr_reg;
   logic [11:0] slot_limit;
   logic [11:0] reg_limit;
   logic [16:0] duty_limit;
   logic        reg_over;
   logic        supply_ok;

   assign cfg = hst_cfg_t'(cfg_bytes_reg);

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         cfg_bytes_reg <= {`HST_RST_REG_FILTER, `HST_RST_RETRY_TERM, `HST_RST_SLOTS_23,
                           `HST_RST_SLOTS_01, `HST_RST_INIT_DETECT};
      else if (cfg_wr && !config_lock && cfg_addr <= `HST_OFS_REG_FILTER)
         cfg_bytes_reg[cfg_addr * 8 +: 8] <= cfg_wdata;
   end

   // Unmapped offsets read as zero.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         cfg_rdata <= 8'h00;
      else if (cfg_addr <= `HST_OFS_REG_FILTER)
         cfg_rdata <= cfg_bytes_reg[cfg_addr * 8 +: 8];
      else
         cfg_rdata <= 8'h00;
   end

   // Pin levels come from comparators and other chips, so two flip-flops each.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= '0;
         pins     <= '0;
      end
      else
      begin
         meta_reg <= {pin_detect_in, under_voltage, over_voltage, converter_good_in, regulating_in, fet_on_in};
         pins     <= meta_reg;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick_cnt_reg <= 16'h0000;
         tick_reg     <= 1'b0;
      end
      else
      begin
         tick_reg     <= (tick_cnt_reg == 16'(TICK_CYCLES - 1));
         tick_cnt_reg <= (tick_cnt_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_reg + 16'h0001;
      end
   end

   // voltage filter; disabled filter trips at once
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         filt_cnt_reg   <= 12'h000;
         volt_fault_reg <= 1'b0;
      end
      else if (!(pins.under_v || pins.over_v))
      begin
         filt_cnt_reg   <= 12'h000;
         volt_fault_reg <= 1'b0;
      end
      else if (!voltage_filter_en || filt_cnt_reg >= ticks_of(cfg.filt))
         volt_fault_reg <= 1'b1;
      else if (tick_reg)
         filt_cnt_reg <= filt_cnt_reg + 12'h001;
   end

   // regulation limit depends on first power-on
   assign reg_limit = first_pwr_reg ? ticks_of(cfg.reg_init) : ticks_of(cfg.reg_sub);
   assign reg_over  = pins.regulating && reg_cnt_reg >= reg_limit;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         reg_cnt_reg <= 12'h000;
      else if (!(high_side_gate && pins.regulating))
         reg_cnt_reg <= 12'h000;
      else if (tick_reg && reg_cnt_reg != 12'hfff)
         reg_cnt_reg <= reg_cnt_reg + 12'h001;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         first_pwr_reg <= 1'b1;
      else if (state_reg == ST_RUN)
         first_pwr_reg <= 1'b0;
   end

   always_comb
   begin
      case (slot_reg)
         2'd0:    slot_limit = ticks_of(cfg.slot0);
         2'd1:    slot_limit = ticks_of(cfg.slot1);
         2'd2:    slot_limit = ticks_of(cfg.slot2);
         default: slot_limit = ticks_of(cfg.slot3);
      endcase
   end

   assign duty_limit = 17'({5'h00, ticks_of(cfg.duty)} * 17'(`HST_DUTY_SCALE));
   assign supply_ok  = pins.pin_detect && !volt_fault_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (supply_ok)
               state_next = ST_DETECT;
         ST_DETECT:
            if (!supply_ok)
               state_next = ST_IDLE;
            else if (seq_cnt_reg >= 17'(ticks_of(cfg.detect)))
               state_next = ST_RAMP;
         ST_RAMP:
            if (pins.fet_on)
               state_next = ST_SLOT;
         ST_SLOT:
            if (seq_cnt_reg >= 17'(slot_limit))
               state_next = ST_TERM;
         ST_TERM:
            if (pins.good[slot_reg])
               state_next = (slot_reg == 2'd3) ? ST_RUN : ST_SLOT;
            else if (seq_cnt_reg >= 17'(ticks_of(cfg.term)))
               state_next = ST_FAULT;
         ST_RUN:
            state_next = ST_RUN;
         // retry after duty time or manual clear
         ST_FAULT:
            if (auto_fault_clear ? (seq_cnt_reg >= duty_limit) : fault_clear)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
      if (state_reg inside {ST_RAMP, ST_SLOT, ST_TERM, ST_RUN} && (!supply_ok || reg_over))
         state_next = ST_FAULT;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_IDLE;
         slot_reg  <= 2'd0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_next == ST_RAMP)
            slot_reg <= 2'd0;
         else if (state_reg == ST_TERM && state_next == ST_SLOT)
            slot_reg <= slot_reg + 2'd1;
      end
   end

   // sequence counter restarts on every state change
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         seq_cnt_reg <= 17'h00000;
      else if (state_next != state_reg)
         seq_cnt_reg <= 17'h00000;
      else if (tick_reg && seq_cnt_reg != 17'h1ffff)
         seq_cnt_reg <= seq_cnt_reg + 17'h00001;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         high_side_gate       <= 1'b0;
         converter_enable_out <= 4'h0;
         fault_out            <= 1'b0;
         seq_state            <= ST_IDLE;
      end
      else
      begin
         high_side_gate <= state_next inside {ST_RAMP, ST_SLOT, ST_TERM, ST_RUN};
         fault_out      <= (state_next == ST_FAULT);
         seq_state      <= state_next;
         if (!(state_next inside {ST_SLOT, ST_TERM, ST_RUN}))
            converter_enable_out <= 4'h0;
         else if (state_reg == ST_SLOT && state_next == ST_TERM)
            converter_enable_out[slot_reg] <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   chk_lock_write: assert property (config_lock |=> $stable(cfg_bytes_reg))
      else $error("Locked registers changed.");
   chk_gate_first: assert property (|converter_enable_out |-> high_side_gate)
      else $error("Converter enabled without gate.");
   chk_enable_order: assert property (converter_enable_out[1] |-> converter_enable_out[0])
      else $error("Second enable before first.");
   chk_detect_wait: assert property (state_reg == ST_DETECT && seq_cnt_reg < 17'(ticks_of(cfg.detect))
                                     |=> state_reg != ST_RAMP)
      else $error("Gate allowed before detect delay.");
   chk_term_fault: assert property (state_reg == ST_TERM && !pins.good[slot_reg] && supply_ok && !reg_over
                                    && seq_cnt_reg >= 17'(ticks_of(cfg.term)) |=> state_reg == ST_FAULT
                                    && fault_out)
      else $error("Termination timeout did not fault.");
   chk_duty_hold: assert property (state_reg == ST_FAULT && seq_cnt_reg < duty_limit && !fault_clear
                                   |=> state_reg == ST_FAULT)
      else $error("Fault left before duty delay.");
   chk_manual_hold: assert property (state_reg == ST_FAULT && !auto_fault_clear && !fault_clear
                                     |=> state_reg == ST_FAULT)
      else $error("Manual fault cleared itself.");
   chk_fault_off: assert property (state_reg == ST_FAULT |-> ##1 (!high_side_gate && converter_enable_out == 4'h0))
      else $error("Outputs still on in fault.");
   chk_tick_period: assert property (tick_reg |-> $past(tick_cnt_reg) == 16'(TICK_CYCLES - 1))
      else $error("Time base tick misplaced.");
   chk_reg_limit: assert property (reg_over && state_reg inside {ST_RAMP, ST_RUN} |=> state_reg == ST_FAULT)
      else $error("Regulation overrun not faulted.");

   cov_run:   cover property (state_reg == ST_TERM && slot_reg == 2'd3 ##1 state_reg == ST_RUN);
   cov_fault: cover property (state_reg == ST_TERM ##1 state_reg == ST_FAULT);
   cov_retry: cover property (state_reg == ST_FAULT ##1 state_reg == ST_IDLE);
   cov_reg_fault: cover property (reg_over ##1 state_reg == ST_FAULT);

endmodule

// ==== test/hst_conv_model.sv ====
/*
 * Model of the four DC/DC converters behind the enable outputs.
 * Assumes the same clock as the timers; good follows each enable after a
 * short or long delay, or never when respond is low.
 */
module hst_conv_model #(
   parameter int FAST = 2,
   parameter int SLOW = 20
) (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic [3:0] enable,
   input  wire logic       respond,
   input  wire logic       slow,
   output logic      [3:0] good
);
   logic [5:0] cnt_reg [4];
   logic [5:0] lim;

   assign lim = slow ? 6'(SLOW) : 6'(FAST);

   // A converter that is off reports not good, never a stale level.
   always_ff @(posedge clock or negedge arst_n)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (!arst_n || !enable[i] || !respond)
            cnt_reg[i] <= 6'h00;
         else if (cnt_reg[i] != 6'h3f)
            cnt_reg[i] <= cnt_reg[i] + 6'h01;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         good[i] = (cnt_reg[i] >= lim);
   end
endmodule

// ==== test/test_hot_swap_sequence_timers.sv ====
/*
 * Self-checking bench of the hot-swap sequence timers.
 * Assumes a 4-cycle tick, so one timer code step is a few clocks only.
 */
module test_hot_swap_sequence_timers;
   timeunit 1ns;
   timeprecision 100ps;
   import hst_pkg::*;

   logic clock = 0, arst_n = 0, cfg_wr = 0, config_lock = 0;
   logic auto_fault_clear = 0, voltage_filter_en = 0, fault_clear = 0;
   logic pin_detect_in = 0, under_voltage = 0, over_voltage = 0;
   logic fet_on_in = 0, regulating_in = 0, respond = 1, slow = 0, high_side_gate, fault_out;
   logic [2:0] cfg_addr = 3'h0;
   logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
   logic [3:0] converter_good_in, converter_enable_out;
   hst_state_t seq_state;
   int failures = 0, compares = 0, cycles = 0, n;
   logic [7:0] rst_val [5] = '{8'h88, 8'h88, 8'h88, 8'hb8, 8'h88};
   // Short regulation codes in bytes 0 and 4 let both limits trip within a few hundred clocks.
   logic [7:0] cfg_val [5] = '{8'h21, 8'h00, 8'h00, 8'h01, 8'h41};

   hst_timers #(.TICK_CYCLES(4)) hst_timers_i (.clock(clock), .arst_n(arst_n),
      .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .config_lock(config_lock), .auto_fault_clear(auto_fault_clear),
      .voltage_filter_en(voltage_filter_en), .fault_clear(fault_clear),
      .pin_detect_in(pin_detect_in), .under_voltage(under_voltage),
      .over_voltage(over_voltage), .converter_good_in(converter_good_in),
      .regulating_in(regulating_in), .fet_on_in(fet_on_in), .high_side_gate(high_side_gate),
      .converter_enable_out(converter_enable_out), .fault_out(fault_out),
      .seq_state(seq_state));

   hst_conv_model hst_conv_model_i (.clock(clock), .arst_n(arst_n),
      .enable(converter_enable_out), .respond(respond), .slow(slow),
      .good(converter_good_in));

   initial
   begin
      forever #10 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         test_done();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      #2 cfg_wr = 1;
      cfg_addr = a;
      cfg_wdata = d;
      @(posedge clock);
      #2 cfg_wr = 0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      #2 cfg_addr = a;
      repeat (2) @(posedge clock);
      #1 check(cfg_rdata, exp, what);
      #1;
   endtask

   // Counts cycles until the sequencer shows the state, then checks it arrived.
   task automatic wait_state(input hst_state_t s);
      n = 0;
      while (seq_state !== s && n < 3000)
      begin
         @(posedge clock);
         #1 n++;
      end
      check({7'h00, seq_state === s}, 8'h01, "state reached");
      #1;
   endtask

   task automatic rng(input int lo, input int hi, input string what);
      check({7'h00, n >= lo && n <= hi}, 8'h01, what);
   endtask

   task automatic test_done();
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge clock);
      #2 arst_n = 1;
      for (int i = 0; i < 5; i++)
         rd(3'(i), rst_val[i], "reset value");
      rd(3'h5, 8'h00, "unmapped read");
      for (int i = 0; i < 5; i++)
         wr(3'(i), cfg_val[i]);
      for (int i = 0; i < 5; i++)
         rd(3'(i), cfg_val[i], "written value");
      config_lock = 1;
      wr(3'h0, 8'h55);
      config_lock = 0;
      rd(3'h0, cfg_val[0], "locked write");
      wr(3'h6, 8'hff);
      rd(3'h6, 8'h00, "unmapped write");
      for (int i = 0; i < 5; i++)
         rd(3'(i), cfg_val[i], "after stray write");
      // The pass transistor regulates and never turns fully on, so the initial limit trips.
      pin_detect_in = 1;
      regulating_in = 1;
      wait_state(ST_DETECT);
      wait_state(ST_RAMP);
      rng(27, 34, "detect delay");
      wait_state(ST_FAULT);
      rng(124, 130, "initial regulation");
      check({7'h00, high_side_gate}, 8'h00, "gate in fault");
      regulating_in = 0;
      fet_on_in = 1;
      fault_clear = 1;
      @(posedge clock);
      #2 fault_clear = 0;
      wait_state(ST_RUN);
      check({4'h0, converter_enable_out}, 8'h0f, "enables in run");
      check({7'h00, high_side_gate}, 8'h01, "gate in run");
      voltage_filter_en = 1;
      under_voltage = 1;
      repeat (12) @(posedge clock);
      #2 under_voltage = 0;
      repeat (40) @(posedge clock);
      #1 check({5'h00, seq_state}, {5'h00, ST_RUN}, "short glitch");
      #1 over_voltage = 1;
      wait_state(ST_FAULT);
      rng(27, 38, "filter time");
      over_voltage = 0;
      repeat (150) @(posedge clock);
      #1 check({7'h00, fault_out}, 8'h01, "manual fault held");
      #1 fault_clear = 1;
      respond = 0;
      auto_fault_clear = 1;
      @(posedge clock);
      #2 fault_clear = 0;
      wait_state(ST_TERM);
      wait_state(ST_FAULT);
      rng(27, 34, "termination time");
      check({4'h0, converter_enable_out}, 8'h00, "enables in fault");
      wait_state(ST_IDLE);
      rng(107, 114, "duty delay");
      respond = 1;
      slow = 1;
      wait_state(ST_RUN);
      check({7'h00, fault_out}, 8'h00, "slow converters ok");
      // Past the first power-on the later, longer regulation limit applies.
      regulating_in = 1;
      wait_state(ST_FAULT);
      rng(254, 260, "later regulation");
      regulating_in = 0;
      wait_state(ST_RUN);
      pin_detect_in = 0;
      wait_state(ST_FAULT);
      test_done();
   end
endmodule
